// File: pwmt_regs.svh
// register map, field positions and reset values of the pwm timer
// assumes a 32-bit axi4-lite slave, one register per aligned word
`ifndef PWMT_REGS_SVH
`define PWMT_REGS_SVH
`define PWMT_OFF_CNT_LO   5'h00
`define PWMT_OFF_CNT_HI   5'h04
`define PWMT_OFF_CMP_LO   5'h08
`define PWMT_OFF_CMP_HI   5'h0C
`define PWMT_OFF_MODE     5'h10
`define PWMT_OFF_STATUS   5'h14
`define PWMT_MODE_RUN_BIT   0
`define PWMT_MODE_LATCH_BIT 1
`define PWMT_MODE_SEL_LSB   2
`define PWMT_MODE_SRC_LSB   4
`define PWMT_CNT_RST      16'hFFFF
`define PWMT_CMP_RST      16'h0000
`define PWMT_MODE_RST     8'h00
`endif

// File: pwmt_pkg.sv
// types shared by the pwm timer modules
// assumes pwmt_regs.svh supplies the register offsets, field positions and reset values; the mode codes are defined here
package pwmt_pkg;
  typedef enum logic [1:0]
  {
    PWMT_TIMER = 2'b00,
    PWMT_PULSE = 2'b01,
    PWMT_GATED = 2'b10,
    PWMT_PWM   = 2'b11
  } pwmt_mode_t;
endpackage

// File: pwmt_core_if.sv
// carrier between the register slave and the counter core
// assumes one clock; strobes are single-cycle pulses
interface pwmt_core_if;
  logic        load_stb;
  logic [15:0] load_val;
  logic        latch_only;
  logic        run;
  logic [1:0]  src_sel;
  logic [15:0] cmp_val;
  logic [1:0]  mode;
  logic [15:0] count;
  logic        uflow;
  logic        wave;
  modport regs (output load_stb, load_val, latch_only, run, src_sel, cmp_val, mode,
                input count, uflow, wave);
  modport core (input load_stb, load_val, latch_only, run, src_sel, cmp_val, mode,
                output count, uflow, wave);
endinterface

// File: pwmt_core.sv
// down counter, reload latch, prescaler and waveform generation
// assumes the register side delivers one-cycle load strobes
`include "pwmt_regs.svh"
module pwmt_core
  import pwmt_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  pwmt_core_if.core cif
);
  logic [15:0] cnt_q, cnt_d, rld_q, rld_d, cmp_act_q, cmp_act_d;
  logic [6:0]  pre_q, pre_d;
  logic        wave_q, wave_d, uf_q, uf_d, tick;

  // count source: system clock divided by 1, 8, 32 or 128
  always_comb
  begin
    case (cif.src_sel)
      2'b00:   tick = 1'b1;
      2'b01:   tick = (pre_q[2:0] == 3'h7);
      2'b10:   tick = (pre_q[4:0] == 5'h1F);
      default: tick = (pre_q == 7'h7F);
    endcase
    pre_d = cif.run ? pre_q + 7'h01 : 7'h00;
  end

  // counter and waveform next state
  always_comb
  begin
    cnt_d     = cnt_q;
    rld_d     = rld_q;
    cmp_act_d = cmp_act_q;
    wave_d    = wave_q;
    uf_d      = 1'b0;
    if (cif.run && tick)
    begin
      if (cnt_q == 16'h0000)
      begin
        cnt_d     = rld_q;
        uf_d      = 1'b1;
        cmp_act_d = cif.cmp_val; // compare and period switch together
        if (cif.mode == PWMT_PULSE)
          wave_d = ~wave_q;
        else if (cif.mode[1])
          wave_d = 1'b1;    // no trigger, no dummy pulse, kills ignored
      end
      else
      begin
        cnt_d = cnt_q - 16'h0001;
        if (cif.mode[1] && (cnt_q - 16'h0001) == cmp_act_q)
          wave_d = 1'b0;    // high phase length from compare
      end
    end
    // a latch-only load racing an underflow may leave the new value unseen
    if (cif.load_stb)
    begin
      rld_d = cif.load_val;
      if (!cif.latch_only)
      begin
        cnt_d     = cif.load_val; // counter and latch together
        cmp_act_d = cif.cmp_val;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q     <= `PWMT_CNT_RST;
      rld_q     <= `PWMT_CNT_RST;
      cmp_act_q <= `PWMT_CMP_RST;
      pre_q     <= 7'h00;
      wave_q    <= 1'b0;
      uf_q      <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cnt_q     <= cnt_d;
      rld_q     <= rld_d;
      cmp_act_q <= cmp_act_d;
      pre_q     <= pre_d;
      wave_q    <= wave_d;
      uf_q      <= uf_d;
    end
  end

  assign cif.count = cnt_q;
  assign cif.uflow = uf_q;
  assign cif.wave  = wave_q;
endmodule

// File: pwmt_top.sv
// 16-bit down-counting pwm timer with axi4-lite register access
// assumes one clock, software keeping the write and read orders below
// Summary of operation
// - pwm mode: no dummy, trigger, kill inputs
// - period from counter, high from compare
// - latch-only write reloads at next underflow
// - otherwise write loads counter and latch
// - latch-only high write near underflow races
// - new compare and period at underflow
// - count down, underflow reloads from latch
// - underflow sets interrupt request bit
// - output high at each underflow in gated and pwm modes
// - output low on compare match in gated and pwm modes
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "pwmt_regs.svh"
module pwmt_top
  import pwmt_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             waveform_output_pin_o,
  output logic             timer_irq_req_o
);
  pwmt_core_if cif ();

  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [4:0]  awa_q, awa_d;
  logic [7:0]  wd_q, wd_d, lo_buf_q, lo_buf_d, rd_lo_q, rd_lo_d, mode_q, mode_d;
  logic [15:0] cmp_q, cmp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        req_q, req_d, wave_q, ld_q, ld_d;
  logic [15:0] ld_val_q, ld_val_d;
  logic        do_wr, do_rd, wr_err, rd_err;

  // is this word offset one of ours
  function automatic logic pwmt_mapped(input logic [4:0] a);
    pwmt_mapped = (a[1:0] == 2'b00) && (a <= `PWMT_OFF_STATUS);
  endfunction

  // axi channel acceptance; address and data taken in either order
  always_comb
  begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    bv_d  = bv_q;
    if (s_axi_awvalid && !aw_q && !bv_q)
    begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !bv_q)
    begin
      w_d  = 1'b1;
      wd_d = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    end
    do_wr  = aw_q && w_q && !bv_q;
    wr_err = !pwmt_mapped(awa_q) || awa_q == `PWMT_OFF_STATUS;
    if (do_wr)
    begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
    end
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
  end

  // register writes; counter bytes commit as one 16-bit load
  always_comb
  begin
    lo_buf_d = lo_buf_q;
    cmp_d    = cmp_q;
    mode_d   = mode_q;
    ld_d     = 1'b0;
    ld_val_d = ld_val_q;
    if (do_wr && !wr_err)
    begin
      case (awa_q)
        `PWMT_OFF_CNT_LO: lo_buf_d = wd_q; // held until high byte
        `PWMT_OFF_CNT_HI:
        begin
          ld_d     = 1'b1;                 // single commit point
          ld_val_d = {wd_q, lo_buf_q};
        end
        `PWMT_OFF_CMP_LO: cmp_d[7:0]  = wd_q;
        `PWMT_OFF_CMP_HI: cmp_d[15:8] = wd_q;
        `PWMT_OFF_MODE:   mode_d      = wd_q;
        default:          mode_d      = mode_q;
      endcase
    end
  end

  // read channel; high byte read snapshots the low byte
  always_comb
  begin
    rv_d    = rv_q;
    rdata_d = rdata_q;
    rd_lo_d = rd_lo_q;
    do_rd   = s_axi_arvalid && !rv_q;
    rd_err  = !pwmt_mapped(s_axi_araddr);
    if (do_rd)
    begin
      rv_d = 1'b1;
      case (s_axi_araddr)
        `PWMT_OFF_CNT_LO: rdata_d = {24'h000000, rd_lo_q};
        `PWMT_OFF_CNT_HI:
        begin
          rdata_d = {24'h000000, cif.count[15:8]};
          rd_lo_d = cif.count[7:0];        // coherent low byte
        end
        `PWMT_OFF_CMP_LO: rdata_d = {24'h000000, cmp_q[7:0]};
        `PWMT_OFF_CMP_HI: rdata_d = {24'h000000, cmp_q[15:8]};
        `PWMT_OFF_MODE:   rdata_d = {24'h000000, mode_q};
        `PWMT_OFF_STATUS: rdata_d = {30'h00000000, req_q, cif.wave};
        default:          rdata_d = 32'h00000000;
      endcase
    end
    else if (rv_q && s_axi_rready)
      rv_d = 1'b0;
  end

  // request bit: underflow sets it; a status write is refused, so only reset clears it
  always_comb
  begin
    req_d = req_q;
    if (cif.uflow)
      req_d = 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awa_q    <= 5'h00;
      wd_q     <= 8'h00;
      bv_q     <= 1'b0;
      rv_q     <= 1'b0;
      rdata_q  <= 32'h00000000;
      rd_lo_q  <= 8'h00;
      lo_buf_q <= 8'h00;
      cmp_q    <= `PWMT_CMP_RST;
      mode_q   <= `PWMT_MODE_RST;
      req_q    <= 1'b0;
      wave_q   <= 1'b0;
      ld_q     <= 1'b0;
      ld_val_q <= 16'h0000;
    end
    else if (clk_en_i)
    begin
      aw_q     <= aw_d;
      w_q      <= w_d;
      awa_q    <= awa_d;
      wd_q     <= wd_d;
      bv_q     <= bv_d;
      rv_q     <= rv_d;
      rdata_q  <= rdata_d;
      rd_lo_q  <= rd_lo_d;
      lo_buf_q <= lo_buf_d;
      cmp_q    <= cmp_d;
      mode_q   <= mode_d;
      req_q    <= req_d;
      wave_q   <= cif.wave;
      ld_q     <= ld_d;
      ld_val_q <= ld_val_d;
    end
  end

  // error answers are registered with the flag that caused them; readies are
  // registered from the next state so that every bus output leaves a flop
  logic bresp_err_q, rresp_err_q, aw_rdy_q, w_rdy_q, ar_rdy_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bresp_err_q <= 1'b0;
      rresp_err_q <= 1'b0;
      aw_rdy_q    <= 1'b1;
      w_rdy_q     <= 1'b1;
      ar_rdy_q    <= 1'b1;
    end
    else if (clk_en_i)
    begin
      aw_rdy_q <= !aw_d && !bv_d;
      w_rdy_q  <= !w_d && !bv_d;
      ar_rdy_q <= !rv_d;
      if (do_wr)
        bresp_err_q <= wr_err;
      if (do_rd)
        rresp_err_q <= rd_err;
    end
  end

  assign s_axi_awready         = aw_rdy_q;
  assign s_axi_wready          = w_rdy_q;
  assign s_axi_bvalid          = bv_q;
  assign s_axi_bresp           = {bresp_err_q, 1'b0};
  assign s_axi_arready         = ar_rdy_q;
  assign s_axi_rvalid          = rv_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = {rresp_err_q, 1'b0};
  assign waveform_output_pin_o = wave_q;
  assign timer_irq_req_o       = req_q;

  // mode fields steer the core; latch-only and stop are software's duty
  assign cif.load_stb   = ld_q;
  assign cif.load_val   = ld_val_q;
  assign cif.run        = mode_q[`PWMT_MODE_RUN_BIT];
  assign cif.latch_only = mode_q[`PWMT_MODE_LATCH_BIT];
  assign cif.mode       = mode_q[`PWMT_MODE_SEL_LSB +: 2];
  assign cif.src_sel    = mode_q[`PWMT_MODE_SRC_LSB +: 2];
  assign cif.cmp_val    = cmp_q;

  pwmt_core u_core
  (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .cif        (cif)
  );
endmodule

// File: pwmt_stage_model.sv
// power stage on the waveform pin: times high phase and period
// assumes one clock; counts are whole cycles between pin edges
module pwmt_stage_model
(
  input  wire logic core_clk_i,
  input  wire logic gate_i,
  output int        period_o,
  output int        high_o,
  output int        rises_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int   n = 0;
  logic g_q = 1'b0;
  // stage on at a rising pin, off at a falling one
  always @(posedge core_clk_i)
  begin
    g_q <= gate_i;
    n <= n + 1;
    if (gate_i && !g_q)
    begin
      rises_o <= rises_o + 1;
      period_o <= n;
      n <= 1;
    end
    if (!gate_i && g_q)
      high_o <= n;
  end
endmodule

// File: pwmt_asserts.sv
// port checks of the pwm timer
// assumes it is bound into pwmt_top and sees its ports only
module pwmt_asserts
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic waveform_output_pin_o,
  input wire logic timer_irq_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // bus answers come at fixed distances and block new requests
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer stands");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer stands");
  // the request bit only falls by reset; freeze holds the waveform pin and the request bit
  a_irq_sticky: assert property (timer_irq_req_o |=> timer_irq_req_o)
    else $error("request bit fell");
  a_rise_sets_irq: assert property ($rose(waveform_output_pin_o)
    |-> ##[0:1] timer_irq_req_o) else $error("underflow without request");
  a_freeze_holds: assert property (!clk_en_i |=> $stable(waveform_output_pin_o)
    && $stable(timer_irq_req_o)) else $error("outputs moved while frozen");
endmodule
bind pwmt_top pwmt_asserts chk (.*);

// File: testbench.sv
// bench of the pwm timer: bus traffic, counter access, pwm timing
// assumes the stage model times the waveform pin in cycles
`include "pwmt_regs.svh"
module testbench
  import pwmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [4:0]  s_axi_awaddr = 5'h00;
  logic [4:0]  s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, lfsr, rd;
  logic        waveform_output_pin_o, timer_irq_req_o;
  logic [15:0] n, c;
  int          bad_count = 0, tests_run = 0, per, hi, rises;

  always #12.5 core_clk_i = ~core_clk_i;
  pwmt_top dut (.*);
  pwmt_stage_model stage (.core_clk_i(core_clk_i), .gate_i(waveform_output_pin_o),
    .period_o(per), .high_o(hi), .rises_o(rises));

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // clock cycles per count step of each source
  function automatic logic [31:0] step_div(input logic [1:0] s);
    return (s == 2'h0) ? 32'h1 : (32'h8 << (2 * (s - 2'h1)));
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic time_out;
    bad_count++;
    $display("MISMATCH at %0t: wait ran out", $time);
    tally_and_finish;
  endtask
  // one bus transfer; ready is looked at before the edge that takes it
  // one transfer at a time, so counter reads and writes never interleave
  task automatic xfer(input logic we, input logic [4:0] a, input logic [31:0] wd);
    logic done, aw, w, ar;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_arvalid <= !we;
    for (int k = 0; k < 100 && !done; k++)
    begin
      @(negedge core_clk_i);
      aw = (s_axi_awvalid & s_axi_awready) === 1'b1;
      w = (s_axi_wvalid & s_axi_wready) === 1'b1;
      ar = (s_axi_arvalid & s_axi_arready) === 1'b1;
      done = (we ? s_axi_bvalid : s_axi_rvalid) === 1'b1;
      rd = s_axi_rdata;
      rsp = we ? s_axi_bresp : s_axi_rresp;
      @(posedge core_clk_i);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      if (ar)
        s_axi_arvalid <= 1'b0;
    end
    if (!done)
      time_out;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd[7:0], e);
    check(rsp, 2'h0);
  endtask
  // compare bytes, then counter low, then counter high, always as one set
  task automatic load(input logic [15:0] cnt, input logic [15:0] cmp);
    xfer(1'b1, `PWMT_OFF_CMP_LO, {24'h0, cmp[7:0]});
    xfer(1'b1, `PWMT_OFF_CMP_HI, {24'h0, cmp[15:8]});
    xfer(1'b1, `PWMT_OFF_CNT_LO, {24'h0, cnt[7:0]});
    xfer(1'b1, `PWMT_OFF_CNT_HI, {24'h0, cnt[15:8]});
  endtask
  task automatic wait_rises(input int k);
    int r0;
    r0 = rises;
    for (int t = 0; t < 20000 && rises < r0 + k; t++)
      @(negedge core_clk_i);
    if (rises < r0 + k)
      time_out;
    else
      @(posedge core_clk_i);
  endtask

  initial
  begin
    lfsr = 32'h50E2;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd_chk(`PWMT_OFF_CNT_HI, 8'hFF);
    rd_chk(`PWMT_OFF_CNT_LO, 8'hFF);
    rd_chk(`PWMT_OFF_CMP_LO, 8'h00);
    rd_chk(`PWMT_OFF_CMP_HI, 8'h00);
    rd_chk(`PWMT_OFF_MODE, 8'h00);
    check(timer_irq_req_o, 1'b0);
    // unmapped and misaligned reads and status writes get a slave error
    xfer(1'b0, 5'h18, 32'h0);
    check(rsp, 2'h2);
    xfer(1'b0, 5'h01, 32'h0);
    check(rsp, 2'h2);
    xfer(1'b1, `PWMT_OFF_STATUS, 32'h2);
    check(rsp, 2'h2);
    // stopped, direct loads; a lone low byte stays in its buffer
    load(16'h1234, 16'h0000);
    rd_chk(`PWMT_OFF_CNT_HI, 8'h12);
    rd_chk(`PWMT_OFF_CNT_LO, 8'h34);
    xfer(1'b1, `PWMT_OFF_CNT_LO, 32'h56);
    rd_chk(`PWMT_OFF_CNT_LO, 8'h34);
    xfer(1'b1, `PWMT_OFF_CNT_HI, 32'h78);
    rd_chk(`PWMT_OFF_CNT_HI, 8'h78);
    rd_chk(`PWMT_OFF_CNT_LO, 8'h56);
    // latch-only load leaves the stopped counter alone
    xfer(1'b1, `PWMT_OFF_MODE, 32'h2);
    load(16'h0009, 16'h0000);
    rd_chk(`PWMT_OFF_CNT_HI, 8'h78);
    rd_chk(`PWMT_OFF_CNT_LO, 8'h56);
    // every source; gated and pwm alternate; random period, compare zero on the first pass and random after
    for (int i = 0; i < 4; i++)
    begin
      lfsr = next_rand(lfsr);
      n = {12'h001, lfsr[3:0]};
      c = (i == 0) ? 16'h0000 : {12'h000, lfsr[7:4]};
      // no kill inputs are wired, so gated mode starts with them inactive
      xfer(1'b1, `PWMT_OFF_MODE, {26'h0, i[1:0], 4'h0});
      load(n, c);
      xfer(1'b1, `PWMT_OFF_MODE, {26'h0, i[1:0], i[0] ? PWMT_PWM : PWMT_GATED, 2'h3});
      clk_en_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      clk_en_i <= 1'b1;
      wait_rises(2);
      check(per, ({16'h0, n} + 32'h1) * step_div(i[1:0]));
      check(hi, {16'h0, n - c} * step_div(i[1:0]));
    end
    check(timer_irq_req_o, 1'b1);
    xfer(1'b0, `PWMT_OFF_STATUS, 32'h0);
    check(rd[1], 1'b1);
    // a status write is refused and leaves the request bit standing
    xfer(1'b1, `PWMT_OFF_STATUS, 32'h2);
    check(rsp, 2'h2);
    check(timer_irq_req_o, 1'b1);
    // write just after a rise, far from the next underflow
    wait_rises(1);
    lfsr = next_rand(lfsr);
    c = n;
    n = {12'h002, lfsr[3:0]};
    load(n, {12'h000, lfsr[7:4]});
    wait_rises(1);
    check(per, ({16'h0, c} + 32'h1) * 32'h80);
    wait_rises(1);
    check(per, ({16'h0, n} + 32'h1) * 32'h80);
    check(hi, {16'h0, n - {12'h000, lfsr[7:4]}} * 32'h80);
    // stop first, then change source; pulse mode toggles the pin per underflow
    xfer(1'b1, `PWMT_OFF_MODE, 32'h3E);
    xfer(1'b1, `PWMT_OFF_MODE, 32'h0);
    lfsr = next_rand(lfsr);
    n = {12'h001, lfsr[3:0]};
    xfer(1'b1, `PWMT_OFF_CNT_LO, {24'h0, n[7:0]});
    xfer(1'b1, `PWMT_OFF_CNT_HI, {24'h0, n[15:8]});
    xfer(1'b1, `PWMT_OFF_MODE, {28'h0, PWMT_PULSE, 2'h1});
    wait_rises(2);
    check(per, ({16'h0, n} + 32'h1) * 32'h2);
    check(hi, {16'h0, n} + 32'h1);
    // a second reset in mid-run brings back the reset values
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd_chk(`PWMT_OFF_CNT_HI, 8'hFF);
    rd_chk(`PWMT_OFF_CNT_LO, 8'hFF);
    check(timer_irq_req_o, 1'b0);
    check(waveform_output_pin_o, 1'b0);
    tally_and_finish;
  end
endmodule
